// *** verilog/rdm_decode.sv ***
// Purpose: Decodes the delivery kind of a remap table entry and steers it.
// Assumes: One entry offered per cycle with entry_strobe_in; same clock.
// Notes:   Outputs are one-cycle pulses per destination agent, except ext_vector_out, which holds the last acknowledge vector.
//
// Notes on behaviour
// - Kind 100b: non-maskable to all, no vector.
// - Kind 100b is always edge, trigger ignored.
// - Kind 101b: restart to all, no vector.
// - Kind 101b is always edge, trigger ignored.
// - Restart kind may be left out.
// - Kind 111b raises request pin of each agent.
// - Kind 111b vector comes from acknowledge cycle.
// - Kind 111b is always edge, trigger ignored.
// - Decode only when entry valid bit set.
// - Field at 7:5; fixed all, lowest one.
// - Kind 010b: system management, edge, no vector.
// - Trigger bit 4: 0 edge, 1 level.
`timescale 1ns/1ps
`default_nettype none
`include "rdm_defines.svh"
module rdm_decode
   import rdm_pkg::*;
#(
   parameter bit RESTART_SUPPORTED = 1'b1
)(
   input  wire logic                    clock_in,
   input  wire logic                    reset_in,
   input  wire logic                    entry_strobe_in,
   input  wire logic [`RDM_ENTRY_W-1:0] remap_table_entry_in,
   input  wire rdm_dest_t               dest_in,
   input  wire logic                    interrupt_acknowledge_cycle_in,
   input  wire logic [7:0]              ack_vector_in,
   output rdm_dest_t                    fixed_out,
   output logic [7:0]                   vector_out,
   output logic                         level_out,
   output rdm_dest_t                    nmi_out,
   output rdm_dest_t                    restart_out,
   output rdm_dest_t                    system_management_irq_out,
   output rdm_dest_t                    processor_interrupt_request_pin_out,
   output logic [7:0]                   ext_vector_out,
   output logic                         ext_vector_valid_out,
   output logic                         unsupported_out
);
   // ---------------------------------------------------------------
   // Field extraction
   // ---------------------------------------------------------------
   logic [2:0] delivery_kind;
   logic       trigger_kind;
   logic       entry_live;
   assign delivery_kind = remap_table_entry_in[`RDM_DK_HI:`RDM_DK_LO];
   assign trigger_kind  = remap_table_entry_in[`RDM_TK_BIT];
   assign entry_live    = entry_strobe_in && remap_table_entry_in[`RDM_VALID_BIT];

   rdm_dest_t lowest_pick;
   logic      lowest_step;
   assign lowest_step = entry_live && delivery_kind == `RDM_DK_LOWEST;

   rdm_agent_select u_select (
      .clock_in            (clock_in),
      .reset_in            (reset_in),
      .step_in             (lowest_step),
      .mask_in             (dest_in),
      .pick_out_unused_out (),
      .pick_out            (lowest_pick)
   );

   // ---------------------------------------------------------------
   // Decode registers
   // ---------------------------------------------------------------
   rdm_dest_t  fixed_q, fixed_d, nmi_q, nmi_d, rst_q, rst_d, smi_q, smi_d;
   rdm_dest_t  req_q, req_d;
   logic [7:0] vec_q, vec_d;
   logic       lvl_q, lvl_d, uns_q, uns_d, lowest_q, lowest_d;

   always_comb begin
      fixed_d  = '0;
      nmi_d    = '0;
      rst_d    = '0;
      smi_d    = '0;
      req_d    = '0;
      vec_d    = 8'h00;
      lvl_d    = 1'b0;
      uns_d    = 1'b0;
      lowest_d = 1'b0;
      if (entry_live) begin
         case (delivery_kind)
            `RDM_DK_FIXED: begin
               fixed_d = dest_in;
               vec_d   = remap_table_entry_in[`RDM_VEC_HI:`RDM_VEC_LO];
               lvl_d   = trigger_kind;
            end
            `RDM_DK_LOWEST: begin
               lowest_d = 1'b1;
               vec_d    = remap_table_entry_in[`RDM_VEC_HI:`RDM_VEC_LO];
               lvl_d    = trigger_kind;
            end
            // Kinds below are edge events; trigger bit and vector are ignored.
            `RDM_DK_SMI: smi_d = dest_in;
            `RDM_DK_NMI: nmi_d = dest_in;
            `RDM_DK_RESTART: begin
               if (RESTART_SUPPORTED) begin
                  rst_d = dest_in;
               end else begin
                  uns_d = 1'b1;
               end
            end
            `RDM_DK_EXTCTL: req_d = dest_in;
            default: uns_d = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         fixed_q  <= '0;
         nmi_q    <= '0;
         rst_q    <= '0;
         smi_q    <= '0;
         req_q    <= '0;
         vec_q    <= 8'h00;
         lvl_q    <= 1'b0;
         uns_q    <= 1'b0;
         lowest_q <= 1'b0;
      end else begin
         fixed_q  <= fixed_d;
         nmi_q    <= nmi_d;
         rst_q    <= rst_d;
         smi_q    <= smi_d;
         req_q    <= req_d;
         vec_q    <= vec_d;
         lvl_q    <= lvl_d;
         uns_q    <= uns_d;
         lowest_q <= lowest_d;
      end
   end

   // ---------------------------------------------------------------
   // Acknowledge vector capture
   // ---------------------------------------------------------------
   // The external-controller vector is taken from the agent's acknowledge.
   logic [7:0] ack_q, ack_d;
   logic       ackv_q, ackv_d;
   always_comb begin
      ack_d  = ack_q;
      ackv_d = 1'b0;
      if (interrupt_acknowledge_cycle_in) begin
         ack_d  = ack_vector_in;
         ackv_d = 1'b1;
      end
   end
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         ack_q  <= 8'h00;
         ackv_q <= 1'b0;
      end else begin
         ack_q  <= ack_d;
         ackv_q <= ackv_d;
      end
   end

   assign fixed_out                           = lowest_q ? lowest_pick : fixed_q;
   assign vector_out                          = vec_q;
   assign level_out                           = lvl_q;
   assign nmi_out                             = nmi_q;
   assign restart_out                         = rst_q;
   assign system_management_irq_out           = smi_q;
   assign processor_interrupt_request_pin_out = req_q;
   assign ext_vector_out                      = ack_q;
   assign ext_vector_valid_out                = ackv_q;
   assign unsupported_out                     = uns_q;
endmodule
`default_nettype wire

// *** verilog/rdm_defines.svh ***
// Purpose: Constants for the remap delivery decoder.
// Assumes: Entry low byte holds trigger and delivery fields.
// Notes:   Included by the package and the modules.
`ifndef RDM_DEFINES_SVH
`define RDM_DEFINES_SVH
`define RDM_DK_HI        7
`define RDM_DK_LO        5
`define RDM_TK_BIT       4
`define RDM_VALID_BIT    0
`define RDM_VEC_HI       23
`define RDM_VEC_LO       16
`define RDM_DST_W        8
`define RDM_ENTRY_W      32
`define RDM_DK_FIXED     3'h0
`define RDM_DK_LOWEST    3'h1
`define RDM_DK_SMI       3'h2
`define RDM_DK_NMI       3'h4
`define RDM_DK_RESTART   3'h5
`define RDM_DK_EXTCTL    3'h7
`endif

// *** verilog/rdm_pkg.sv ***
// Purpose: Types for the remap delivery decoder.
// Assumes: rdm_defines.svh gives the widths.
// Notes:   Types only.
`include "rdm_defines.svh"
package rdm_pkg;
   typedef logic [`RDM_DST_W-1:0] rdm_dest_t;
   typedef enum logic [1:0] {
      RDM_IDLE = 2'h0,
      RDM_WAIT = 2'h1
   } rdm_state_e;
endpackage

// *** verilog/rdm_agent_select.sv ***
// Purpose: Picks one destination agent for lowest-priority delivery.
// Assumes: Round robin stands in for a priority scheme.
// Notes:   Output is registered; empty mask gives zero.
`timescale 1ns/1ps
`default_nettype none
`include "rdm_defines.svh"
module rdm_agent_select
   import rdm_pkg::*;
(
   input  wire logic      clock_in,
   input  wire logic      reset_in,
   input  wire logic      step_in,
   input  wire rdm_dest_t mask_in,
   output logic           pick_out_unused_out,
   output rdm_dest_t      pick_out
);
   rdm_dest_t pick_q;
   rdm_dest_t pick_d;
   logic [2:0] ptr_q;
   logic [2:0] ptr_d;
   logic [3:0] idx;
   always_comb begin
      pick_d = '0;
      ptr_d  = ptr_q;
      idx    = 4'h0;
      for (int i = 0; i < `RDM_DST_W; i++) begin
         idx = 4'(ptr_q) + 4'(i);
         if (pick_d == '0 && mask_in[idx[2:0]]) begin
            pick_d = rdm_dest_t'(8'h01 << idx[2:0]);
            if (step_in) begin
               ptr_d = idx[2:0] + 3'h1;
            end
         end
      end
   end
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         pick_q <= '0;
         ptr_q  <= 3'h0;
      end else begin
         pick_q <= pick_d;
         ptr_q  <= ptr_d;
      end
   end
   assign pick_out            = pick_q;
   assign pick_out_unused_out = 1'b0;
endmodule
`default_nettype wire

// *** bench/rdm_agent_model.sv ***
// Purpose: Processor agent that answers a request pin with an acknowledge.
// Assumes: Acknowledge follows the request pulse half a cycle later.
// Notes:   Vector lines show the inverse value while idle.
`timescale 1ns/1ps
`default_nettype none
module rdm_agent_model #(
   parameter logic [7:0] VEC = 8'h3C
)(
   input  wire logic       clk_in,
   input  wire logic [7:0] req_in,
   output var logic        ack_out,
   output var logic [7:0]  vec_out
);
   initial ack_out = 1'b0;
   initial vec_out = ~VEC;
   always @(negedge clk_in) begin
      ack_out <= |req_in;
      vec_out <= (|req_in) ? VEC : ~VEC;
   end
endmodule
`default_nettype wire

// *** bench/rdm_decode_sva.sv ***
// Purpose: Port assertions for the delivery decoder.
// Assumes: Restart kind is supported.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module rdm_decode_sva
   import rdm_pkg::*;
(
   input wire logic        clock_in,
   input wire logic        reset_in,
   input wire logic        entry_strobe_in,
   input wire logic [31:0] remap_table_entry_in,
   input wire rdm_dest_t   dest_in,
   input wire logic        interrupt_acknowledge_cycle_in,
   input wire logic [7:0]  ack_vector_in,
   input wire rdm_dest_t   fixed_out,
   input wire logic [7:0]  vector_out,
   input wire logic        level_out,
   input wire rdm_dest_t   nmi_out,
   input wire rdm_dest_t   restart_out,
   input wire rdm_dest_t   system_management_irq_out,
   input wire rdm_dest_t   processor_interrupt_request_pin_out,
   input wire logic [7:0]  ext_vector_out,
   input wire logic        ext_vector_valid_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (reset_in);
   wire logic       v = entry_strobe_in & remap_table_entry_in[0];
   wire logic [2:0] k = remap_table_entry_in[7:5];
   nmi_a: assert property (v && k == 3'h4 |=> nmi_out == $past(dest_in) && vector_out == 8'h00)
      else $error("nmi pulse wrong");
   edge_a: assert property (v && k[2] |=> !level_out)
      else $error("level seen on edge kind");
   restart_a: assert property (v && k == 3'h5 |=> restart_out == $past(dest_in))
      else $error("restart pulse wrong");
   request_pin_a: assert property (v && k == 3'h7 |=> processor_interrupt_request_pin_out == $past(dest_in))
      else $error("request pin wrong");
   ack_vec_a: assert property (interrupt_acknowledge_cycle_in |=> ext_vector_valid_out && ext_vector_out == $past(ack_vector_in))
      else $error("acknowledge vector wrong");
   invalid_quiet_a: assert property (!v |=> (nmi_out | restart_out | fixed_out | processor_interrupt_request_pin_out) == 8'h00)
      else $error("output without valid entry");
   fixed_all_a: assert property (v && k == 3'h0 |=> fixed_out == $past(dest_in) && level_out == $past(remap_table_entry_in[4]))
      else $error("fixed delivery wrong");
   smi_a: assert property (v && k == 3'h2 |=> system_management_irq_out == $past(dest_in) && vector_out == 8'h00 && !level_out)
      else $error("management pulse wrong");
   cover property (v && k == 3'h4);
   cover property (v && k == 3'h7);
   cover property (interrupt_acknowledge_cycle_in);
endmodule
`default_nettype wire

// *** bench/rdm_decode_tb.sv ***
// Purpose: Walks every delivery kind with the valid bit clear and set.
// Assumes: Destination mask 06 and trigger bit set on every entry.
// Notes:   Trigger set shows that edge-only kinds ignore it.
`timescale 1ns/1ps
`default_nettype none
module rdm_decode_tb
   import rdm_pkg::*;
;
   logic        clock_in = 1'b0;
   logic        reset_in = 1'b1;
   logic        entry_strobe_in = 1'b0;
   logic [31:0] remap_table_entry_in = 32'h0;
   rdm_dest_t   dest_in = 8'h06;
   logic        interrupt_acknowledge_cycle_in;
   logic [7:0]  ack_vector_in, vector_out, ext_vector_out;
   rdm_dest_t   fixed_out, nmi_out, restart_out, system_management_irq_out;
   rdm_dest_t   processor_interrupt_request_pin_out;
   logic        level_out, ext_vector_valid_out, unsupported_out;
   int          n_mismatch = 0;
   int          checked = 0;
   wire logic [49:0] obs = {fixed_out, vector_out, level_out, nmi_out, restart_out,
                            system_management_irq_out, processor_interrupt_request_pin_out,
                            unsupported_out};
   always #25 clock_in = ~clock_in;
   rdm_decode dut (
      .clock_in                            (clock_in),
      .reset_in                            (reset_in),
      .entry_strobe_in                     (entry_strobe_in),
      .remap_table_entry_in                (remap_table_entry_in),
      .dest_in                             (dest_in),
      .interrupt_acknowledge_cycle_in      (interrupt_acknowledge_cycle_in),
      .ack_vector_in                       (ack_vector_in),
      .fixed_out                           (fixed_out),
      .vector_out                          (vector_out),
      .level_out                           (level_out),
      .nmi_out                             (nmi_out),
      .restart_out                         (restart_out),
      .system_management_irq_out           (system_management_irq_out),
      .processor_interrupt_request_pin_out (processor_interrupt_request_pin_out),
      .ext_vector_out                      (ext_vector_out),
      .ext_vector_valid_out                (ext_vector_valid_out),
      .unsupported_out                     (unsupported_out)
   );
   rdm_agent_model agent (.clk_in(clock_in), .req_in(processor_interrupt_request_pin_out),
                          .ack_out(interrupt_acknowledge_cycle_in), .vec_out(ack_vector_in));
   function automatic logic [49:0] want(input logic [2:0] k);
      case (k)
         3'h0: want = {8'h06, 8'hA5, 1'b1, 33'h0};
         3'h1: want = {8'h02, 8'hA5, 1'b1, 33'h0};
         3'h2: want = {33'h0, 8'h06, 9'h0};
         3'h4: want = {17'h0, 8'h06, 25'h0};
         3'h5: want = {25'h0, 8'h06, 17'h0};
         3'h7: want = {41'h0, 8'h06, 1'b0};
         default: want = {49'h0, 1'b1};
      endcase
   endfunction
   task automatic chk(input logic [49:0] got, input logic [49:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge clock_in);
      reset_in = 1'b0;
      for (int v = 0; v < 2; v++) begin
         for (int k = 0; k < 8; k++) begin
            @(negedge clock_in);
            entry_strobe_in = 1'b1;
            remap_table_entry_in = {16'h00A5, 8'h00, k[2:0], 1'b1, 3'h0, v[0]};
            @(negedge clock_in);
            entry_strobe_in = 1'b0;
            chk(obs, v ? want(k[2:0]) : 50'h0);
            if (v == 1 && k == 7) begin
               @(negedge clock_in);
               chk({ext_vector_valid_out, ext_vector_out}, {1'b1, 8'h3C});
            end
         end
         $display("kind walk with valid bit %0d done", v);
      end
      tally_and_finish();
   end
   initial begin
      #100000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule
bind rdm_decode rdm_decode_sva chk (.*);
`default_nettype wire
